// ===== verilog/rsc_pkg.sv
// Package of constants for the reset source control block
package rsc_pkg;
    // Reset cause bit positions
    localparam int CAUSE_W = 6;
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_POR = 1;
    localparam int CAUSE_BOR = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_SW = 4;
    localparam int CAUSE_OSC = 5;
    // Reset value of the cause register after an internal power-on reset
    localparam logic [5:0] CAUSE_POR_VAL = 6'h02;
    // Cycles the internal reset stays asserted after all sources go quiet
    localparam logic [3:0] RELEASE_CYCLES = 4'h4;
    // Cycles from internal release until the core is let run (vector fetch window)
    localparam logic [3:0] FETCH_CYCLES = 4'h3;
    // Release sequencer states
    typedef enum logic [1:0] {
        RSC_HOLD,
        RSC_COUNT,
        RSC_FETCH,
        RSC_RUN
    } rsc_state_t;
endpackage

// ===== verilog/rsc_sync3.sv
// Three-stage synchroniser that reports a change once stages two and three agree
module rsc_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic out_q;
    logic out_d;

    always_comb begin
        stage_d = {stage_q[1:0], async_in};
        out_d = out_q;
        if (stage_q[1] == stage_q[2]) begin
            out_d = stage_q[2];
        end
        if (!rst_n) begin
            stage_d = {3{RESET_VAL}};
            out_d = RESET_VAL;
        end
    end

    always_ff @(posedge ref_clk) begin
        stage_q <= stage_d;
        out_q <= out_d;
    end

    assign sync_out = out_q;
endmodule

// ===== verilog/rsc_periph_reset.sv
// Per-peripheral software reset: a set-then-clear of a control bit resets the unit
module rsc_periph_reset #(
    parameter int N_PERIPH = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [N_PERIPH-1:0] periph_reset_ctrl_regs,
    input wire logic system_reset,
    output logic [N_PERIPH-1:0] periph_rst
);
    logic [N_PERIPH-1:0] ctrl_q;
    logic [N_PERIPH-1:0] ctrl_d;
    logic [N_PERIPH-1:0] rst_q;
    logic [N_PERIPH-1:0] rst_d;

    genvar i;
    generate
        for (i = 0; i < N_PERIPH; i++) begin : g_per
            always_comb begin
                ctrl_d[i] = periph_reset_ctrl_regs[i];
                // Reset held while the bit is set and pulsed once more on clear [RULE5] [RULE18]
                rst_d[i] = periph_reset_ctrl_regs[i] | (ctrl_q[i] & ~periph_reset_ctrl_regs[i]);
                if (system_reset) begin
                    rst_d[i] = 1'b1;
                end
                if (!rst_n) begin
                    ctrl_d[i] = 1'b0;
                    rst_d[i] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        ctrl_q <= ctrl_d;
        rst_q <= rst_d;
    end

    assign periph_rst = rst_q;

    property p_clear_pulse;
        @(posedge ref_clk) disable iff (!rst_n) (ctrl_q[0] && !periph_reset_ctrl_regs[0]) |=> periph_rst[0];
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) // [RULE18]
        else $error("Peripheral reset missing after control bit cleared");
endmodule

// ===== verilog/rsc_top.sv
// Reset source aggregation, release sequencing and cause recording
// Function
// [RULE1] Six reset sources feed the block
// [RULE2] Power-on resets core, peripherals and debug port
// [RULE3] Pin reset spares debug port state
// [RULE4] Other system resets spare debug port
// [RULE5] Peripheral reset touches only selected units
// [RULE6] Each reset sets its cause bit
// [RULE7] Cause bits are sticky across resets
// [RULE8] Power-on clears all causes but its own
// [RULE9] Hold reset until power-on ends, then fetch
// [RULE10] Power-on detector only at first power-up
// [RULE11] Pin held minimum time, then release and fetch
// [RULE12] Brown-out reset disabled until software enables
// [RULE13] Brown-out raises interrupt or reset
// [RULE14] Brown-out resets only when enable bit set
// [RULE15] Brown-out reset held while supply low
// [RULE16] Read-only identification values exposed
// [RULE17] Interrupt pin stays general purpose until committed
// [RULE18] Set-then-clear of peripheral bit resets it
// [RULE19] System request bit resets whole system
// [RULE20] Asynchronous sources synchronised before release
// [RULE21] Software clears individual cause bits
module rsc_top #(
    parameter int N_PERIPH = 32,
    parameter logic [31:0] IDENT_A = 32'h00010000, // Arbitrary value
    parameter logic [31:0] IDENT_B = 32'h00000001, // Arbitrary value
    parameter logic [31:0] CAPABILITY = 32'h0000ffff // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ext_reset_pin_n,
    input wire logic power_on_detect,
    input wire logic low_supply_detector,
    input wire logic watchdog_reset,
    input wire logic main_oscillator_fail,
    input wire logic system_reset_request_bit,
    input wire logic [N_PERIPH-1:0] periph_reset_ctrl_regs,
    input wire logic brownout_reset_enable_wr,
    input wire logic brownout_reset_enable_val,
    input wire logic [5:0] cause_clear,
    input wire logic alt_function_select_wr,
    input wire logic alt_function_select_val,
    input wire logic alt_function_commit,
    output logic core_rst,
    output logic core_run,
    output logic debug_rst,
    output logic debug_pin_cfg_rst,
    output logic [N_PERIPH-1:0] periph_rst,
    output logic brownout_irq,
    output logic brownout_reset_enable,
    output logic [5:0] reset_cause_reg,
    output logic pin_alt_function_reg,
    output logic [31:0] device_ident_reg_a,
    output logic [31:0] device_ident_reg_b,
    output logic [31:0] device_capability_regs
);
    logic pin_n_s;
    logic por_s;
    logic bor_s;
    logic wdt_s;
    logic osc_s;
    logic sys_req_q;
    logic sys_req_d;
    logic por_seen_q;
    logic por_seen_d;
    logic sys_src;
    logic por_src;

    // Pin-level sources pass the three-stage synchroniser [RULE20]
    rsc_sync3 #(.RESET_VAL(1'b1)) u_sync_pin (
        .ref_clk(ref_clk), .rst_n(rst_n), .async_in(ext_reset_pin_n), .sync_out(pin_n_s));
    rsc_sync3 #(.RESET_VAL(1'b1)) u_sync_por (
        .ref_clk(ref_clk), .rst_n(rst_n), .async_in(power_on_detect), .sync_out(por_s));
    rsc_sync3 #(.RESET_VAL(1'b0)) u_sync_bor (
        .ref_clk(ref_clk), .rst_n(rst_n), .async_in(low_supply_detector), .sync_out(bor_s));
    rsc_sync3 #(.RESET_VAL(1'b0)) u_sync_wdt (
        .ref_clk(ref_clk), .rst_n(rst_n), .async_in(watchdog_reset), .sync_out(wdt_s));
    rsc_sync3 #(.RESET_VAL(1'b0)) u_sync_osc (
        .ref_clk(ref_clk), .rst_n(rst_n), .async_in(main_oscillator_fail), .sync_out(osc_s));

    // Brown-out enable, cleared by every system reset [RULE12]
    logic bor_en_q;
    logic bor_en_d;
    logic bor_rst;

    // Power-on is honoured only until it first goes inactive [RULE10]
    assign por_src = por_s & ~por_seen_q;
    assign bor_rst = bor_s & bor_en_q; // [RULE14] [RULE15]
    // Any of the six sources resets core and peripherals; brown-out only when enabled, power-on only at first power-up [RULE1] [RULE4]
    assign sys_src = por_src | ~pin_n_s | bor_rst | wdt_s | osc_s | sys_req_q;

    always_comb begin
        sys_req_d = system_reset_request_bit; // [RULE19]
        por_seen_d = por_seen_q | ~por_s;
        if (!rst_n) begin
            sys_req_d = 1'b0;
            por_seen_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        sys_req_q <= sys_req_d;
        por_seen_q <= por_seen_d;
    end

    // Release sequencer
    rsc_pkg::rsc_state_t state_q;
    rsc_pkg::rsc_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic core_rst_q;
    logic core_rst_d;
    logic core_run_q;
    logic core_run_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            rsc_pkg::RSC_HOLD: begin
                // Wait for power-on, pin, brown-out and others to go quiet [RULE9] [RULE11]
                if (!sys_src) begin
                    state_d = rsc_pkg::RSC_COUNT;
                    cnt_d = rsc_pkg::RELEASE_CYCLES;
                end
            end
            rsc_pkg::RSC_COUNT: begin
                if (sys_src) begin
                    state_d = rsc_pkg::RSC_HOLD;
                end else if (cnt_q == 4'h1) begin
                    state_d = rsc_pkg::RSC_FETCH;
                    cnt_d = rsc_pkg::FETCH_CYCLES;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            rsc_pkg::RSC_FETCH: begin
                // Stack pointer, program counter and first opcode fetch window [RULE9]
                if (sys_src) begin
                    state_d = rsc_pkg::RSC_HOLD;
                end else if (cnt_q == 4'h1) begin
                    state_d = rsc_pkg::RSC_RUN;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            rsc_pkg::RSC_RUN: begin
                if (sys_src) begin
                    state_d = rsc_pkg::RSC_HOLD;
                end
            end
            default: begin
                state_d = rsc_pkg::RSC_HOLD;
            end
        endcase
        if (!rst_n) begin
            state_d = rsc_pkg::RSC_HOLD;
            cnt_d = 4'h0;
        end
        core_rst_d = (state_d == rsc_pkg::RSC_HOLD) || (state_d == rsc_pkg::RSC_COUNT);
        core_run_d = (state_d == rsc_pkg::RSC_RUN);
    end

    always_ff @(posedge ref_clk) begin
        state_q <= state_d;
        cnt_q <= cnt_d;
        core_rst_q <= core_rst_d;
        core_run_q <= core_run_d;
    end

    assign core_rst = core_rst_q;
    assign core_run = core_run_q;

    // Debug port: full reset only on power-on, pin only touches its pin setup
    logic debug_rst_q;
    logic debug_rst_d;
    logic dbg_pin_q;
    logic dbg_pin_d;

    always_comb begin
        debug_rst_d = por_src; // [RULE2] [RULE4]
        dbg_pin_d = por_src | ~pin_n_s; // [RULE3]
        if (!rst_n) begin
            debug_rst_d = 1'b1;
            dbg_pin_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        debug_rst_q <= debug_rst_d;
        dbg_pin_q <= dbg_pin_d;
    end

    assign debug_rst = debug_rst_q;
    assign debug_pin_cfg_rst = dbg_pin_q;

    // Peripherals: system reset on every unit, software reset per unit [RULE2] [RULE5]
    rsc_periph_reset #(.N_PERIPH(N_PERIPH)) u_periph (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .periph_reset_ctrl_regs(periph_reset_ctrl_regs),
        .system_reset(core_rst_d),
        .periph_rst(periph_rst)
    );

    // Brown-out control and interrupt
    logic bor_irq_q;
    logic bor_irq_d;

    always_comb begin
        bor_en_d = bor_en_q;
        if (brownout_reset_enable_wr) begin
            bor_en_d = brownout_reset_enable_val;
        end
        if (core_rst_q && !bor_rst) begin
            bor_en_d = 1'b0; // [RULE12]
        end
        // With reset disabled the condition is reported as an interrupt [RULE13]
        bor_irq_d = bor_s & ~bor_en_q;
        if (!rst_n) begin
            bor_en_d = 1'b0;
            bor_irq_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        bor_en_q <= bor_en_d;
        bor_irq_q <= bor_irq_d;
    end

    assign brownout_reset_enable = bor_en_q;
    assign brownout_irq = bor_irq_q;

    // Sticky cause register; a new event wins over a software clear
    logic [5:0] cause_q;
    logic [5:0] cause_d;
    logic [5:0] cause_set;

    always_comb begin
        cause_set = 6'h00;
        cause_set[rsc_pkg::CAUSE_EXT] = ~pin_n_s;
        cause_set[rsc_pkg::CAUSE_BOR] = bor_rst;
        cause_set[rsc_pkg::CAUSE_WDT] = wdt_s;
        cause_set[rsc_pkg::CAUSE_SW] = sys_req_q;
        cause_set[rsc_pkg::CAUSE_OSC] = osc_s;
        cause_d = (cause_q & ~cause_clear) | cause_set; // [RULE6] [RULE7] [RULE21]
        if (por_src) begin
            cause_d = rsc_pkg::CAUSE_POR_VAL; // [RULE8]
        end
        if (!rst_n) begin
            cause_d = rsc_pkg::CAUSE_POR_VAL;
        end
    end

    always_ff @(posedge ref_clk) begin
        cause_q <= cause_d;
    end

    assign reset_cause_reg = cause_q;

    // Interrupt pin function select, needs commit [RULE17]
    logic alt_q;
    logic alt_d;
    logic [31:0] id_a_q;
    logic [31:0] id_b_q;
    logic [31:0] cap_q;

    always_comb begin
        alt_d = alt_q;
        if (alt_function_select_wr && alt_function_commit) begin
            alt_d = alt_function_select_val;
        end
        if (core_rst_q || !rst_n) begin
            alt_d = 1'b0;
        end
    end

    // Identification values are constants; registered only to drive from flops [RULE16]
    always_ff @(posedge ref_clk) begin
        alt_q <= alt_d;
        id_a_q <= IDENT_A;
        id_b_q <= IDENT_B;
        cap_q <= CAPABILITY;
    end

    assign pin_alt_function_reg = alt_q;
    assign device_ident_reg_a = id_a_q;
    assign device_ident_reg_b = id_b_q;
    assign device_capability_regs = cap_q;

    property p_por_all;
        @(posedge ref_clk) disable iff (!rst_n) por_src |=> (debug_rst && core_rst);
    endproperty
    a_por_all: assert property (p_por_all) else $error("Power-on did not reset debug port and core"); // [RULE2]
    property p_pin_no_dbg;
        @(posedge ref_clk) disable iff (!rst_n) (!pin_n_s && !por_src) |=> (!debug_rst && debug_pin_cfg_rst);
    endproperty
    a_pin_no_dbg: assert property (p_pin_no_dbg) else $error("Pin reset touched debug state"); // [RULE3]
    property p_por_cause;
        @(posedge ref_clk) disable iff (!rst_n) por_src |=> (reset_cause_reg == rsc_pkg::CAUSE_POR_VAL);
    endproperty
    a_por_cause: assert property (p_por_cause) else $error("Power-on cause value wrong"); // [RULE8]
    property p_sticky;
        @(posedge ref_clk) disable iff (!rst_n)
            (reset_cause_reg[3] && !cause_clear[3] && !por_src) |=> reset_cause_reg[3];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Cause bit lost"); // [RULE7]
    property p_wdt_cause;
        @(posedge ref_clk) disable iff (!rst_n) (wdt_s && !por_src) |=> reset_cause_reg[3];
    endproperty
    a_wdt_cause: assert property (p_wdt_cause) else $error("Watchdog cause not recorded"); // [RULE6]
    property p_bor_gate;
        @(posedge ref_clk) disable iff (!rst_n) (bor_s && !bor_en_q) |=> brownout_irq;
    endproperty
    a_bor_gate: assert property (p_bor_gate) else $error("Brown-out interrupt missing"); // [RULE13]
    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n) sys_src |=> core_rst;
    endproperty
    a_hold: assert property (p_hold) else $error("Core released while a source is active"); // [RULE15]
    // A source arriving inside the fetch window sends the core back to hold, so only the last count is judged
    property p_release;
        @(posedge ref_clk) disable iff (!rst_n)
            (state_q == rsc_pkg::RSC_FETCH && cnt_q == 4'h1 && !sys_src) |=> core_run;
    endproperty
    a_release: assert property (p_release) else $error("Core did not start after fetch window"); // [RULE9]
    property p_alt;
        @(posedge ref_clk) disable iff (!rst_n)
            (alt_function_select_wr && !alt_function_commit && !core_rst_q) |=> $stable(pin_alt_function_reg);
    endproperty
    a_alt: assert property (p_alt) else $error("Alternate function changed without commit"); // [RULE17]
endmodule

// ===== tb/rsc_supply_model.sv
// Model of the external reset circuit and the supply monitor
module rsc_supply_model #(
    parameter int T_MIN = 8
) (
    input wire logic ref_clk,
    output logic ext_reset_pin_n,
    output logic power_on_detect,
    output logic low_supply_detector
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ext_reset_pin_n = 1'b1;
        power_on_detect = 1'b1;
        low_supply_detector = 1'b0;
    end
    // Power-on detector drops once and stays low afterwards
    task automatic por_end(input int n);
        repeat (n) @(negedge ref_clk);
        power_on_detect <= 1'b0;
    endtask
    // Stray power-on pulse in mid-run, which the block must ignore
    task automatic por_glitch(input int n);
        power_on_detect <= 1'b1;
        repeat (n) @(negedge ref_clk);
        power_on_detect <= 1'b0;
    endtask
    // Short requests are stretched, since a pulse under the minimum may be missed
    task automatic pin_pulse(input int n);
        ext_reset_pin_n <= 1'b0;
        repeat ((n < T_MIN) ? T_MIN : n) @(negedge ref_clk);
        ext_reset_pin_n <= 1'b1;
    endtask
    task automatic supply(input logic low, input int n);
        low_supply_detector <= low;
        repeat (n) @(negedge ref_clk);
    endtask
endmodule

// ===== tb/reset_source_control_tb_top.sv
// Self-checking bench for the reset source control block
module reset_source_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NP = 32;
    localparam logic [31:0] ID_A = 32'h00a51234; // Arbitrary value
    localparam logic [31:0] ID_B = 32'h00005a01; // Arbitrary value
    localparam logic [31:0] CAP = 32'h0000c3c3; // Arbitrary value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_reset_pin_n, power_on_detect, low_supply_detector;
    logic [2:0] src_v = 3'h0;
    logic [NP-1:0] preg = 32'h0;
    logic en_wr = 1'b0, en_val = 1'b0, alt_wr = 1'b0, alt_val = 1'b0, alt_commit = 1'b0;
    logic [5:0] clr = 6'h0;
    logic core_rst, core_run, debug_rst, debug_pin_cfg_rst, brownout_irq, brownout_reset_enable, alt_q;
    logic [NP-1:0] periph_rst;
    logic [5:0] reset_cause_reg;
    logic [31:0] id_a, id_b, cap;
    int err_count = 0, comparisons = 0;
    integer seed = 43448;
    logic [5:0] exp_cause;
    logic [9:0] exp_q[$];
    logic [9:0] note;
    logic dbg_seen = 1'b0, pin_seen = 1'b0, per_all = 1'b1, run_prev = 1'b0;

    always #12.5 ref_clk = ~ref_clk;

    rsc_supply_model #(.T_MIN(8)) model (.ref_clk(ref_clk), .ext_reset_pin_n(ext_reset_pin_n),
        .power_on_detect(power_on_detect), .low_supply_detector(low_supply_detector));

    rsc_top #(.N_PERIPH(NP), .IDENT_A(ID_A), .IDENT_B(ID_B), .CAPABILITY(CAP)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ext_reset_pin_n(ext_reset_pin_n),
        .power_on_detect(power_on_detect), .low_supply_detector(low_supply_detector),
        .watchdog_reset(src_v[0]), .main_oscillator_fail(src_v[1]), .system_reset_request_bit(src_v[2]),
        .periph_reset_ctrl_regs(preg), .brownout_reset_enable_wr(en_wr), .brownout_reset_enable_val(en_val),
        .cause_clear(clr), .alt_function_select_wr(alt_wr), .alt_function_select_val(alt_val),
        .alt_function_commit(alt_commit), .core_rst(core_rst), .core_run(core_run), .debug_rst(debug_rst),
        .debug_pin_cfg_rst(debug_pin_cfg_rst), .periph_rst(periph_rst), .brownout_irq(brownout_irq),
        .brownout_reset_enable(brownout_reset_enable), .reset_cause_reg(reset_cause_reg),
        .pin_alt_function_reg(alt_q), .device_ident_reg_a(id_a), .device_ident_reg_b(id_b),
        .device_capability_regs(cap));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    // Note layout: pin-care flag, expected cause, debug, pin config, all peripherals
    task automatic expect_seq(input logic care_pin, input logic dbg, input logic pin);
        exp_q.push_back({care_pin, exp_cause, dbg, pin, 1'b1});
    endtask
    task automatic wait_run();
        int n = 0;
        while (core_run !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (core_run !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED core_run expected 1 seen %b", core_run);
        end
        @(negedge ref_clk);
    endtask
    task automatic alt_write(input logic commit);
        alt_wr <= 1'b1;
        alt_val <= 1'b1;
        alt_commit <= commit;
        @(negedge ref_clk);
        alt_wr <= 1'b0;
        alt_commit <= 1'b0;
        @(negedge ref_clk);
    endtask

    // Sequence monitor: collects what each reset touched, judged when the core is let run
    always @(negedge ref_clk) begin
        if (core_rst === 1'b1) begin
            dbg_seen <= dbg_seen | debug_rst;
            pin_seen <= pin_seen | debug_pin_cfg_rst;
            per_all <= per_all & (&periph_rst);
        end
        run_prev <= core_run;
        if (core_run === 1'b1 && run_prev === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("CHECK FAILED reset sequence expected none seen %h", reset_cause_reg);
            end else begin
                note = exp_q.pop_front();
                chk("reset sequence", {23'h0, note[8:0]},
                    {23'h0, reset_cause_reg, dbg_seen, note[9] ? pin_seen : note[1], per_all});
            end
            dbg_seen <= 1'b0;
            pin_seen <= 1'b0;
            per_all <= 1'b1;
        end
    end

    initial begin
        #(30000 * 25);
        err_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        int k;
        logic [5:0] m;
        logic [31:0] p;
        exp_cause = 6'h02;
        expect_seq(1'b1, 1'b1, 1'b1);
        repeat (4) @(negedge ref_clk);
        rst_n <= 1'b1;
        repeat (20) @(negedge ref_clk);
        chk("core_rst under power-on", 32'h1, {31'h0, core_rst});
        model.por_end(0);
        wait_run();
        model.por_glitch(10);
        chk("core_rst late power-on", 32'h0, {31'h0, core_rst});
        chk("cause late power-on", 32'h02, {26'h0, reset_cause_reg});
        done("power-on");
        exp_cause = 6'h03;
        expect_seq(1'b1, 1'b0, 1'b1);
        model.pin_pulse(2);
        wait_run();
        done("pin");
        chk("brownout_reset_enable", 32'h0, {31'h0, brownout_reset_enable});
        model.supply(1'b1, 20);
        chk("brownout_irq", 32'h1, {31'h0, brownout_irq});
        chk("core_rst brownout off", 32'h0, {31'h0, core_rst});
        model.supply(1'b0, 10);
        chk("brownout_irq", 32'h0, {31'h0, brownout_irq});
        chk("cause brownout off", 32'h03, {26'h0, reset_cause_reg});
        en_wr <= 1'b1;
        en_val <= 1'b1;
        @(negedge ref_clk);
        en_wr <= 1'b0;
        @(negedge ref_clk);
        chk("brownout_reset_enable", 32'h1, {31'h0, brownout_reset_enable});
        exp_cause = 6'h07;
        expect_seq(1'b1, 1'b0, 1'b0);
        model.supply(1'b1, 40);
        chk("core_rst in brownout", 32'h1, {31'h0, core_rst});
        model.supply(1'b0, 0);
        wait_run();
        chk("brownout_reset_enable", 32'h0, {31'h0, brownout_reset_enable});
        done("brown-out");
        alt_write(1'b0);
        chk("alt function no commit", 32'h0, {31'h0, alt_q});
        alt_write(1'b1);
        chk("alt function commit", 32'h1, {31'h0, alt_q});
        // Enable armed again so the system resets below must clear it
        en_wr <= 1'b1;
        @(negedge ref_clk);
        en_wr <= 1'b0;
        @(negedge ref_clk);
        chk("brownout_reset_enable armed", 32'h1, {31'h0, brownout_reset_enable});
        for (int i = 0; i < 6; i++) begin
            k = {$random(seed)} % 3;
            exp_cause = exp_cause | ((k == 0) ? 6'h08 : (k == 1) ? 6'h20 : 6'h10);
            expect_seq(1'b1, 1'b0, 1'b0);
            src_v[k] <= 1'b1;
            repeat (6 + {$random(seed)} % 6) @(negedge ref_clk);
            chk("core_rst under source", 32'h1, {31'h0, core_rst});
            src_v[k] <= 1'b0;
            wait_run();
        end
        chk("alt function after reset", 32'h0, {31'h0, alt_q});
        chk("brownout_reset_enable", 32'h0, {31'h0, brownout_reset_enable});
        done("system sources");
        m = 6'h3f & $random(seed);
        clr <= m;
        @(negedge ref_clk);
        clr <= 6'h0;
        @(negedge ref_clk);
        exp_cause = exp_cause & ~m;
        chk("cause clear", {26'h0, exp_cause}, {26'h0, reset_cause_reg});
        done("cause clear");
        p = $random(seed);
        preg <= p;
        repeat (2) @(negedge ref_clk);
        chk("periph_rst set", p, periph_rst);
        chk("core_rst periph", 32'h0, {31'h0, core_rst});
        preg <= 32'h0;
        @(negedge ref_clk);
        chk("periph_rst tail", p, periph_rst);
        repeat (2) @(negedge ref_clk);
        chk("periph_rst clear", 32'h0, periph_rst);
        done("peripheral");
        chk("ident a", ID_A, id_a);
        chk("ident b", ID_B, id_b);
        chk("capability", CAP, cap);
        done("ident");
        summarize();
    end
endmodule
